// [cmc_cfg.svh]
// Constants of the configuration memory CRC checker: polynomial, seeds, clock divider limits.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

// Check word width and ANSI CRC-16 generator x^16 + x^15 + x^2 + 1
`define CMC_SIG_W 16
`define CMC_CRC_POLY 16'h8005
`define CMC_CRC_INIT 16'h0000
// Syndrome of an error in the very last bit of a frame: x^16 mod g
`define CMC_SYN_SEED 16'h8005

// Oscillator rate and divider exponent limits (divide by 2 to 256)
`define CMC_OSC_MHZ 100
`define CMC_DIV_LOG2_MIN 1
`define CMC_DIV_LOG2_MAX 8
`define CMC_DIV_RST 8'h00

`endif

// [cmc_pkg.sv]
// Types shared by the configuration memory CRC checker.
// Assumes nothing beyond a SystemVerilog compiler.
package cmc_pkg;

	typedef enum logic [5:0] {
		CMC_IDLE = 6'b00_0001,
		CMC_CFG = 6'b00_0010,
		CMC_FAIL = 6'b00_0100,
		CMC_USER = 6'b00_1000,
		CMC_PRIME = 6'b01_0000,
		CMC_CHK = 6'b10_0000
	} cmc_state_e;

	typedef enum logic [1:0] {
		CMC_ERR_NONE = 2'h0,
		CMC_ERR_SINGLE = 2'h1,
		CMC_ERR_DOUBLE = 2'h2,
		CMC_ERR_UNKNOWN = 2'h3
	} cmc_err_e;

endpackage

// [cmc_crc_step.sv]
// Parallel CRC-16 step: advances a check word over N data bits, MSB first.
// Assumes a purely combinational use; with all-zero data it multiplies by x^N mod g.
`timescale 1ns/1ps
`include "cmc_cfg.svh"

module cmc_crc_step #(
	parameter int N = 1
) (
	// Check word in and out
	input wire logic [15:0] crc_in,
	output logic [15:0] crc_out,
	// Data bits, highest first
	input wire logic [N-1:0] data_in
);

	always_comb begin
		crc_out = crc_in;
		for (int i = N - 1; i >= 0; i--) begin
			if (crc_out[15] ^ data_in[i]) begin
				crc_out = {crc_out[14:0], 1'b0} ^ `CMC_CRC_POLY;
			end else begin
				crc_out = {crc_out[14:0], 1'b0};
			end
		end
	end

endmodule

// [cmc_sig_mem.sv]
// Per-frame check bit store: one 16-bit word per frame, registered read.
// Assumes a single writer; read data follow the address by one clock.
`timescale 1ns/1ps

module cmc_sig_mem #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [15:0] wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output logic [15:0] rd_data
);

	logic [15:0] mem [DEPTH];

	// Array itself carries no reset; contents are always written before use
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

// [cmc_checker.sv]
// Configuration memory CRC checker: frame checks while loading, background checks in user mode.
// Assumes a synchronous readback port on the configuration memory cells with one cycle latency,
// DATA_W a power of two, and all inputs synchronous to mclk (the 100 MHz oscillator).
//
// Functional notes
// - Configuration frames checked against embedded CRC
// - Sixteen check bits stored per loaded frame
// - Same polynomial for configuration and background
// - Background check loops until reconfig request low
// - Background check only if enabled, after user mode
// - Check clock is oscillator divided 2..256
// - Zero signature means clean, flag low
// - Non-zero signature starts error location search
// - Error flag high on detected bit error
// - All one, two, three bit errors detected
// - Locate singles and adjacent doubles, classify type
// - Location readable by JTAG and core port
// - Unread location overwritten by newer one
// - Checking continues to next frame regardless
// - Generator is the ANSI CRC-16 polynomial
// - Signature storage is 16 bits per frame
// - Only configuration frames checked, no memories
`timescale 1ns/1ps
`include "cmc_cfg.svh"

module cmc_checker #(
	parameter int NUM_FRAMES = 64,
	parameter int FRAME_WORDS = 8,
	parameter int DATA_W = 16,
	parameter int DIV_LOG2 = 1,
	parameter bit BG_ENABLE = 1'b1,
	parameter int FAW = (NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1,
	parameter int WAW = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS) : 1,
	parameter int BW = $clog2(FRAME_WORDS * DATA_W + `CMC_SIG_W + 1)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Reconfiguration request
	input wire logic reconfig_request_n,
	// Configuration stream
	input wire logic cfg_valid,
	input wire logic [DATA_W-1:0] cfg_data,
	input wire logic cfg_crc_valid,
	input wire logic [15:0] cfg_crc,
	// Configuration status
	output logic cfg_done,
	output logic cfg_error,
	// Configuration memory readback
	output logic mem_rd_en,
	output logic [FAW-1:0] mem_rd_frame,
	output logic [WAW-1:0] mem_rd_word,
	input wire logic [DATA_W-1:0] mem_rd_data,
	// Error reporting to core logic
	output logic crc_error,
	output logic loc_valid,
	output logic [FAW-1:0] loc_frame,
	output logic [BW-1:0] loc_bit,
	output logic [1:0] loc_type,
	input wire logic core_loc_ack,
	// JTAG readout
	input wire logic error_location_shift_instr,
	input wire logic jtag_capture,
	input wire logic jtag_shift,
	output logic jtag_tdo
);

	////////////////////////////////////////////////////////////////////////////////
	// Sizes and constants

	localparam int DATA_BITS = FRAME_WORDS * DATA_W;
	localparam int TOTAL = DATA_BITS + `CMC_SIG_W;
	localparam int OW = (DATA_W > 1) ? $clog2(DATA_W) : 1;
	localparam int LOCW = 2 + FAW + BW;
	localparam logic [BW-1:0] LAST_BIT = BW'(TOTAL - 1);
	localparam logic [BW-1:0] DATA_LAST = BW'(DATA_BITS - 1);
	localparam logic [BW-1:0] DATA_END = BW'(DATA_BITS);
	localparam logic [OW-1:0] OFF_LAST = OW'(DATA_W - 1);
	localparam logic [FAW-1:0] FRAME_LAST = FAW'(NUM_FRAMES - 1);
	localparam logic [WAW-1:0] WORD_LAST = WAW'(FRAME_WORDS - 1);
	// Divider fixed at build time; slower checks widen the readout window
	localparam logic [7:0] DIV_LAST = 8'((1 << DIV_LOG2) - 1);

	typedef struct packed {
		cmc_pkg::cmc_state_e st;
		logic [7:0] div_cnt;
		logic [FAW-1:0] frame;
		logic [WAW-1:0] word;
		logic [BW-1:0] bit_idx;
		logic [15:0] crc;
		logic [DATA_W-1:0] shreg;
		logic [DATA_W-1:0] nxt_word;
		logic [15:0] sig_sh;
		logic rd_wait;
		logic mem_rd_en;
		logic [FAW-1:0] mem_rd_frame;
		logic [WAW-1:0] mem_rd_word;
		logic cfg_done;
		logic cfg_error;
		logic crc_error;
		logic srch_on;
		logic [15:0] srch_r;
		logic [BW-1:0] srch_j;
		logic [15:0] srch_tgt;
		logic [FAW-1:0] srch_frame;
		logic loc_valid;
		logic [FAW-1:0] loc_frame;
		logic [BW-1:0] loc_bit;
		cmc_pkg::cmc_err_e loc_type;
		logic [LOCW-1:0] jsh;
		logic jtag_tdo;
	} cmc_regs_s;

	cmc_regs_s s;
	cmc_regs_s next_s;

	////////////////////////////////////////////////////////////////////////////////
	// CRC engines and signature store

	logic [15:0] crc_cfg;
	logic [15:0] crc_bit;
	logic [15:0] srch_rx;
	logic [15:0] sig_rd;
	logic bit_in;
	logic in_data;
	logic tick;
	logic sig_wr;
	logic [FAW-1:0] frame_next;

	assign tick = (s.div_cnt == DIV_LAST);
	assign in_data = (s.bit_idx < DATA_END);
	assign bit_in = in_data ? s.shreg[DATA_W-1] : s.sig_sh[15];
	assign frame_next = (s.frame == FRAME_LAST) ? '0 : s.frame + 1'b1;
	// Only frames that pass are stored; a failing load stops before any further write
	assign sig_wr = (s.st == cmc_pkg::CMC_CFG) && cfg_crc_valid && (s.crc == cfg_crc);

	// Word-parallel engine while loading, bit-serial engine in the background
	cmc_crc_step #(.N(DATA_W)) u_crc_cfg (
		.crc_in(s.crc),
		.crc_out(crc_cfg),
		.data_in(cfg_data)
	);

	cmc_crc_step #(.N(1)) u_crc_bit (
		.crc_in(s.crc),
		.crc_out(crc_bit),
		.data_in(bit_in)
	);

	// Zero data turns the step into multiply by x: next syndrome position
	cmc_crc_step #(.N(1)) u_crc_srch (
		.crc_in(s.srch_r),
		.crc_out(srch_rx),
		.data_in(1'b0)
	);

	cmc_sig_mem #(.DEPTH(NUM_FRAMES), .AW(FAW)) u_sig_mem (
		.mclk(mclk),
		.resetn(resetn),
		.wr_en(sig_wr),
		.wr_addr(s.frame),
		.wr_data(s.crc),
		.rd_addr(s.frame),
		.rd_data(sig_rd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.div_cnt = tick ? `CMC_DIV_RST : s.div_cnt + 8'h01;
		next_s.mem_rd_en = 1'b0;
		next_s.rd_wait = s.mem_rd_en;
		if (s.rd_wait) begin
			next_s.nxt_word = mem_rd_data;
		end

		// Readout: reading clears the pending mark; a new location below wins
		if (core_loc_ack || (error_location_shift_instr && jtag_capture)) begin
			next_s.loc_valid = 1'b0;
		end
		if (error_location_shift_instr && jtag_capture) begin
			next_s.jsh = {s.loc_type, s.loc_frame, s.loc_bit};
			next_s.jtag_tdo = s.loc_bit[0];
		end else if (error_location_shift_instr && jtag_shift) begin
			next_s.jsh = s.jsh >> 1;
			next_s.jtag_tdo = s.jsh[1];
		end

		case (s.st)
			cmc_pkg::CMC_IDLE: begin
				if (reconfig_request_n) begin
					next_s.st = cmc_pkg::CMC_CFG;
				end
			end
			cmc_pkg::CMC_CFG: begin
				if (cfg_valid) begin
					next_s.crc = crc_cfg;
				end
				if (cfg_crc_valid) begin
					next_s.crc = `CMC_CRC_INIT;
					if (s.crc != cfg_crc) begin
						next_s.cfg_error = 1'b1;
						next_s.st = cmc_pkg::CMC_FAIL;
					end else if (s.frame == FRAME_LAST) begin
						next_s.cfg_done = 1'b1;
						next_s.frame = '0;
						next_s.st = cmc_pkg::CMC_USER;
					end else begin
						next_s.frame = frame_next;
					end
				end
			end
			cmc_pkg::CMC_FAIL: begin
				next_s.st = cmc_pkg::CMC_FAIL;
			end
			cmc_pkg::CMC_USER: begin
				if (BG_ENABLE) begin
					next_s.mem_rd_en = 1'b1;
					next_s.mem_rd_frame = '0;
					next_s.mem_rd_word = '0;
					next_s.st = cmc_pkg::CMC_PRIME;
				end
			end
			cmc_pkg::CMC_PRIME: begin
				if (s.rd_wait) begin
					next_s.shreg = mem_rd_data;
					next_s.frame = '0;
					next_s.word = '0;
					next_s.bit_idx = '0;
					next_s.crc = `CMC_CRC_INIT;
					next_s.st = cmc_pkg::CMC_CHK;
				end
			end
			cmc_pkg::CMC_CHK: begin
				if (tick) begin
					// Only configuration frame words are read back, never memory blocks
					if (in_data && (s.bit_idx[OW-1:0] == '0)) begin
						next_s.mem_rd_en = 1'b1;
						if (s.word == WORD_LAST) begin
							next_s.mem_rd_frame = frame_next;
							next_s.mem_rd_word = '0;
						end else begin
							next_s.mem_rd_frame = s.frame;
							next_s.mem_rd_word = s.word + 1'b1;
						end
					end
					next_s.crc = crc_bit;
					if (in_data) begin
						next_s.shreg = {s.shreg[DATA_W-2:0], 1'b0};
					end else begin
						next_s.sig_sh = {s.sig_sh[14:0], 1'b0};
					end
					if (s.bit_idx == DATA_LAST) begin
						next_s.sig_sh = sig_rd;
					end else if (in_data && (s.bit_idx[OW-1:0] == OFF_LAST)) begin
						next_s.shreg = s.nxt_word;
						next_s.word = s.word + 1'b1;
					end

					// Location search, one syndrome position per check tick
					if (s.srch_on) begin
						if (s.srch_r == s.srch_tgt) begin
							next_s.srch_on = 1'b0;
							next_s.loc_valid = 1'b1;
							next_s.loc_frame = s.srch_frame;
							next_s.loc_bit = LAST_BIT - s.srch_j;
							next_s.loc_type = cmc_pkg::CMC_ERR_SINGLE;
						end else if ((s.srch_j != LAST_BIT) && ((s.srch_r ^ srch_rx) == s.srch_tgt)) begin
							next_s.srch_on = 1'b0;
							next_s.loc_valid = 1'b1;
							next_s.loc_frame = s.srch_frame;
							next_s.loc_bit = LAST_BIT - s.srch_j - 1'b1;
							next_s.loc_type = cmc_pkg::CMC_ERR_DOUBLE;
						end else if (s.srch_j == LAST_BIT) begin
							// Other patterns are flagged but cannot be placed
							next_s.srch_on = 1'b0;
							next_s.loc_valid = 1'b1;
							next_s.loc_frame = s.srch_frame;
							next_s.loc_bit = '0;
							next_s.loc_type = cmc_pkg::CMC_ERR_UNKNOWN;
						end else begin
							next_s.srch_j = s.srch_j + 1'b1;
							next_s.srch_r = srch_rx;
						end
					end

					if (s.bit_idx == LAST_BIT) begin
						next_s.bit_idx = '0;
						next_s.word = '0;
						next_s.crc = `CMC_CRC_INIT;
						next_s.shreg = s.nxt_word;
						next_s.frame = frame_next;
						next_s.crc_error = (crc_bit != 16'h0000);
						if (crc_bit != 16'h0000) begin
							// A fresh error restarts the search and replaces any unread one
							next_s.srch_on = 1'b1;
							next_s.srch_r = `CMC_SYN_SEED;
							next_s.srch_j = '0;
							next_s.srch_tgt = crc_bit;
							next_s.srch_frame = s.frame;
						end
					end else begin
						next_s.bit_idx = s.bit_idx + 1'b1;
					end
				end
			end
			default: begin
				next_s.st = cmc_pkg::CMC_IDLE;
			end
		endcase

		// Request low aborts everything and restarts configuration
		if (!reconfig_request_n) begin
			next_s.st = cmc_pkg::CMC_IDLE;
			next_s.frame = '0;
			next_s.word = '0;
			next_s.bit_idx = '0;
			next_s.crc = `CMC_CRC_INIT;
			next_s.cfg_done = 1'b0;
			next_s.cfg_error = 1'b0;
			next_s.crc_error = 1'b0;
			next_s.srch_on = 1'b0;
			next_s.loc_valid = 1'b0;
			next_s.mem_rd_en = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.st <= cmc_pkg::CMC_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign cfg_done = s.cfg_done;
	assign cfg_error = s.cfg_error;
	assign mem_rd_en = s.mem_rd_en;
	assign mem_rd_frame = s.mem_rd_frame;
	assign mem_rd_word = s.mem_rd_word;
	assign crc_error = s.crc_error;
	assign loc_valid = s.loc_valid;
	assign loc_frame = s.loc_frame;
	assign loc_bit = s.loc_bit;
	assign loc_type = s.loc_type;
	assign jtag_tdo = s.jtag_tdo;

endmodule

// [cmc_checker_asserts.sv]
// Port checker for the configuration memory CRC checker.
// Assumes it is bound onto cmc_checker, a single mclk domain.
`timescale 1ns/1ps
module cmc_checker_asserts #(
	parameter int NUM_FRAMES = 64,
	parameter int FRAME_WORDS = 8,
	parameter int DATA_W = 16,
	parameter int DIV_LOG2 = 1,
	parameter bit BG_ENABLE = 1'b1,
	parameter int FAW = 6,
	parameter int WAW = 3,
	parameter int BW = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Watched ports
	input wire logic reconfig_request_n,
	input wire logic cfg_done,
	input wire logic cfg_error,
	input wire logic mem_rd_en,
	input wire logic [FAW-1:0] mem_rd_frame,
	input wire logic [WAW-1:0] mem_rd_word,
	input wire logic crc_error,
	input wire logic loc_valid,
	input wire logic [FAW-1:0] loc_frame,
	input wire logic [BW-1:0] loc_bit,
	input wire logic [1:0] loc_type,
	input wire logic core_loc_ack
);
	// Search may need a whole frame of ticks; slack covers readback gaps
	localparam int LOC_WAIT = 2 * (FRAME_WORDS * DATA_W + 16) * (1 << DIV_LOG2) + 64;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////
	sequence s_abort;
		!reconfig_request_n ##1 !reconfig_request_n;
	endsequence
	sequence s_rd_gap;
		!mem_rd_en [*8];
	endsequence
	property p_rd_pulse;
		mem_rd_en && $past(cfg_done, 2) |=> s_rd_gap;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("readback pulse too close");
	// A read issued while cfg_done was still low two cycles earlier is the priming read, of frame 0, word 0
	property p_rd_prime;
		mem_rd_en && !$past(cfg_done, 2) |-> mem_rd_frame == '0 && mem_rd_word == '0;
	endproperty
	a_rd_prime: assert property (p_rd_prime) else $error("priming read not at frame 0");
	property p_bg_start;
		BG_ENABLE && $rose(cfg_done) |=> mem_rd_en;
	endproperty
	a_bg_start: assert property (p_bg_start) else $error("background check did not start");
	property p_rd_user;
		mem_rd_en |-> cfg_done;
	endproperty
	a_rd_user: assert property (p_rd_user) else $error("readback outside user mode");
	property p_rd_range;
		mem_rd_en |-> mem_rd_frame < NUM_FRAMES && mem_rd_word < FRAME_WORDS;
	endproperty
	a_rd_range: assert property (p_rd_range) else $error("readback outside frames");
	property p_abort;
		s_abort |=> !cfg_done && !cfg_error && !mem_rd_en;
	endproperty
	a_abort: assert property (p_abort) else $error("still running after reconfig");
	property p_sticky;
		cfg_error && reconfig_request_n |=> cfg_error;
	endproperty
	a_sticky: assert property (p_sticky) else $error("config error dropped");
	property p_excl;
		!(cfg_done && cfg_error);
	endproperty
	a_excl: assert property (p_excl) else $error("done and error together");
	property p_type;
		loc_valid |-> loc_type != 2'h0;
	endproperty
	a_type: assert property (p_type) else $error("location without type");
	property p_loc_after_err;
		$rose(crc_error) |-> ##[0:LOC_WAIT] loc_valid;
	endproperty
	a_loc_after_err: assert property (p_loc_after_err) else $error("no location found");
	property p_ack_clr;
		loc_valid && core_loc_ack |=> !loc_valid || $changed(loc_bit) || $changed(loc_frame);
	endproperty
	a_ack_clr: assert property (p_ack_clr) else $error("ack did not clear");
endmodule

bind cmc_checker cmc_checker_asserts #(
	.NUM_FRAMES(NUM_FRAMES), .FRAME_WORDS(FRAME_WORDS), .DATA_W(DATA_W),
	.DIV_LOG2(DIV_LOG2), .BG_ENABLE(BG_ENABLE), .FAW(FAW), .WAW(WAW), .BW(BW)
) u_asserts (
	.mclk(mclk), .resetn(resetn), .reconfig_request_n(reconfig_request_n),
	.cfg_done(cfg_done), .cfg_error(cfg_error), .mem_rd_en(mem_rd_en),
	.mem_rd_frame(mem_rd_frame), .mem_rd_word(mem_rd_word), .crc_error(crc_error),
	.loc_valid(loc_valid), .loc_frame(loc_frame), .loc_bit(loc_bit),
	.loc_type(loc_type), .core_loc_ack(core_loc_ack)
);

// [cmc_mem_model.sv]
// Model of the configuration memory cells behind the readback port.
// Assumes FW a power of two; cells fill from the config stream in order.
`timescale 1ns/1ps
module cmc_mem_model #(
	parameter int NF = 4,
	parameter int FW = 2,
	parameter int FAW = 2,
	parameter int WAW = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Configuration snoop
	input wire logic reconfig_request_n,
	input wire logic cfg_valid,
	input wire logic [15:0] cfg_data,
	// Readback
	input wire logic mem_rd_en,
	input wire logic [FAW-1:0] mem_rd_frame,
	input wire logic [WAW-1:0] mem_rd_word,
	output logic [15:0] mem_rd_data,
	// Upset injection
	input wire logic flip_en,
	input wire logic [FAW-1:0] flip_frame,
	input wire logic [WAW-1:0] flip_word,
	input wire logic [15:0] flip_mask
);
	// Frame cells only; no memory block or I/O bits exist here
	logic [15:0] cells [NF*FW];
	int wr_idx;
	////////////////////////////////
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_idx <= 0;
			mem_rd_data <= 16'h0000;
		end else begin
			if (!reconfig_request_n) begin
				wr_idx <= 0;
			end else if (cfg_valid && wr_idx < NF * FW) begin
				cells[wr_idx] <= cfg_data;
				wr_idx <= wr_idx + 1;
			end
			if (flip_en) begin
				cells[{flip_frame, flip_word}] <= cells[{flip_frame, flip_word}] ^ flip_mask;
			end
			// Off-cycle data inverted so a late sample cannot match by luck
			if (mem_rd_en) begin
				mem_rd_data <= cells[{mem_rd_frame, mem_rd_word}];
			end else begin
				mem_rd_data <= ~mem_rd_data;
			end
		end
	end
endmodule

// [cmc_checker_tb_top.sv]
// Self-checking bench for the configuration memory CRC checker.
// Assumes the memory model and the bound checker are compiled first.
`timescale 1ns/1ps
module cmc_checker_tb_top;
	localparam int NF = 4;
	localparam int FW = 2;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic reconfig_request_n = 1'b0;
	logic cfg_valid = 1'b0;
	logic [15:0] cfg_data = 16'h0000;
	logic cfg_crc_valid = 1'b0;
	logic [15:0] cfg_crc = 16'h0000;
	logic core_loc_ack = 1'b0;
	logic error_location_shift_instr = 1'b0;
	logic jtag_capture = 1'b0;
	logic jtag_shift = 1'b0;
	logic flip_en = 1'b0;
	logic [1:0] flip_frame = 2'h0;
	logic flip_word = 1'b0;
	logic [15:0] flip_mask = 16'h0000;
	logic cfg_done, cfg_error, mem_rd_en, mem_rd_word, crc_error, loc_valid, jtag_tdo;
	logic [1:0] mem_rd_frame, loc_frame, loc_type;
	logic [5:0] loc_bit;
	logic [15:0] mem_rd_data;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	int reads = 0;
	logic off_done, off_rd_en;
	int off_reads = 0;
	cmc_checker #(.NUM_FRAMES(NF), .FRAME_WORDS(FW), .DATA_W(16), .DIV_LOG2(1)) dut (
		.mclk(mclk), .resetn(resetn), .reconfig_request_n(reconfig_request_n),
		.cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_crc_valid(cfg_crc_valid),
		.cfg_crc(cfg_crc), .cfg_done(cfg_done), .cfg_error(cfg_error), .mem_rd_en(mem_rd_en),
		.mem_rd_frame(mem_rd_frame), .mem_rd_word(mem_rd_word), .mem_rd_data(mem_rd_data),
		.crc_error(crc_error), .loc_valid(loc_valid), .loc_frame(loc_frame),
		.loc_bit(loc_bit), .loc_type(loc_type), .core_loc_ack(core_loc_ack),
		.error_location_shift_instr(error_location_shift_instr),
		.jtag_capture(jtag_capture), .jtag_shift(jtag_shift), .jtag_tdo(jtag_tdo)
	);
	cmc_mem_model #(.NF(NF), .FW(FW), .FAW(2), .WAW(1)) u_mem (
		.mclk(mclk), .resetn(resetn), .reconfig_request_n(reconfig_request_n),
		.cfg_valid(cfg_valid), .cfg_data(cfg_data), .mem_rd_en(mem_rd_en),
		.mem_rd_frame(mem_rd_frame), .mem_rd_word(mem_rd_word), .mem_rd_data(mem_rd_data),
		.flip_en(flip_en), .flip_frame(flip_frame), .flip_word(flip_word), .flip_mask(flip_mask)
	);
	// Same stream into a build without the background check; it must never read back
	cmc_checker #(.NUM_FRAMES(NF), .FRAME_WORDS(FW), .DATA_W(16), .DIV_LOG2(1),
		.BG_ENABLE(1'b0)) dut_off (
		.mclk(mclk), .resetn(resetn), .reconfig_request_n(reconfig_request_n),
		.cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_crc_valid(cfg_crc_valid),
		.cfg_crc(cfg_crc), .cfg_done(off_done), .cfg_error(), .mem_rd_en(off_rd_en),
		.mem_rd_frame(), .mem_rd_word(), .mem_rd_data(mem_rd_data),
		.crc_error(), .loc_valid(), .loc_frame(),
		.loc_bit(), .loc_type(), .core_loc_ack(core_loc_ack),
		.error_location_shift_instr(error_location_shift_instr),
		.jtag_capture(jtag_capture), .jtag_shift(jtag_shift), .jtag_tdo()
	);
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		reads += int'(mem_rd_en === 1'b1);
		off_reads += int'(off_rd_en !== 1'b0);
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end
	////////////////////////////////
	function automatic logic [15:0] fword(input int f, input int w);
		return 16'hA5C3 ^ (16'h0111 * f[15:0]) ^ (16'h1000 * w[15:0]);
	endfunction
	// Bitwise MSB-first division by x^16 + x^15 + x^2 + 1
	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 15; i >= 0; i--) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h8005 : 16'h0000);
		return r;
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic restart();
		@(posedge mclk);
		reconfig_request_n <= 1'b0;
		repeat (3) @(posedge mclk);
		reconfig_request_n <= 1'b1;
		@(posedge mclk);
	endtask
	task automatic load(input int bad);
		logic [15:0] c;
		for (int f = 0; f < NF; f++) begin
			c = 16'h0000;
			for (int w = 0; w < FW; w++) begin
				@(posedge mclk);
				cfg_crc_valid <= 1'b0;
				cfg_valid <= 1'b1;
				cfg_data <= fword(f, w);
				c = crc_word(c, fword(f, w));
			end
			@(posedge mclk);
			cfg_valid <= 1'b0;
			cfg_crc_valid <= 1'b1;
			cfg_crc <= (f == bad) ? ~c : c;
		end
		@(posedge mclk);
		cfg_crc_valid <= 1'b0;
	endtask
	task automatic flip(input logic [1:0] f, input logic w, input logic [15:0] m);
		@(posedge mclk);
		flip_en <= 1'b1;
		flip_frame <= f;
		flip_word <= w;
		flip_mask <= m;
		@(posedge mclk);
		flip_en <= 1'b0;
	endtask
	task automatic ack();
		@(posedge mclk);
		core_loc_ack <= 1'b1;
		@(posedge mclk);
		core_loc_ack <= 1'b0;
	endtask
	task automatic t_config();
		restart();
		load(-1);
		repeat (2) @(negedge mclk);
		check(cfg_done, 1'b1);
		check(cfg_error, 1'b0);
		$display("test config done");
	endtask
	task automatic t_clean();
		int r0;
		r0 = reads;
		repeat (800) @(negedge mclk);
		check(reads - r0 >= NF * FW, 1'b1);
		check(crc_error, 1'b0);
		check(loc_valid, 1'b0);
		check(off_done, 1'b1);
		check(16'(off_reads), 16'h0000);
		$display("test clean done");
	endtask
	task automatic t_single();
		flip(2'h2, 1'b1, 16'h0020);
		for (int n = 0; n < 1500 && crc_error !== 1'b1; n++) @(negedge mclk);
		check(crc_error, 1'b1);
		for (int n = 0; n < 300 && loc_valid !== 1'b1; n++) @(negedge mclk);
		check({loc_type, loc_frame, loc_bit}, {2'h1, 2'h2, 6'h1A});
		ack();
		@(negedge mclk);
		check(loc_valid, 1'b0);
		flip(2'h2, 1'b1, 16'h0020);
		for (int n = 0; n < 300 && crc_error !== 1'b0; n++) @(negedge mclk);
		check(crc_error, 1'b0);
		$display("test single done");
	endtask
	task automatic t_jtag();
		logic [9:0] got;
		flip(2'h1, 1'b0, 16'h0180);
		for (int n = 0; n < 1500 && loc_valid !== 1'b1; n++) @(negedge mclk);
		@(posedge mclk);
		error_location_shift_instr <= 1'b1;
		jtag_capture <= 1'b1;
		@(posedge mclk);
		jtag_capture <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk);
			got[i] = jtag_tdo;
			@(posedge mclk);
			jtag_shift <= 1'b1;
			@(posedge mclk);
			jtag_shift <= 1'b0;
		end
		error_location_shift_instr <= 1'b0;
		check(got, {2'h2, 2'h1, 6'h07});
		check(loc_valid, 1'b0);
		flip(2'h1, 1'b0, 16'h0180);
		repeat (500) @(negedge mclk);
		$display("test jtag done");
	endtask
	task automatic t_overwrite();
		flip(2'h0, 1'b0, 16'h0001);
		flip(2'h3, 1'b1, 16'h0841);
		for (int n = 0; n < 1500 && !(loc_valid === 1'b1 && loc_frame === 2'h0); n++) @(negedge mclk);
		check({loc_type, loc_frame, loc_bit}, {2'h1, 2'h0, 6'h0F});
		for (int n = 0; n < 1500 && loc_frame !== 2'h3; n++) @(negedge mclk);
		check({loc_valid, loc_frame}, {1'b1, 2'h3});
		check(loc_type !== 2'h0, 1'b1);
		flip(2'h0, 1'b0, 16'h0001);
		flip(2'h3, 1'b1, 16'h0841);
		repeat (500) @(negedge mclk);
		ack();
		$display("test overwrite done");
	endtask
	task automatic t_mismatch();
		restart();
		check(cfg_done, 1'b0);
		load(1);
		repeat (2) @(negedge mclk);
		check({cfg_error, cfg_done}, 2'h2);
		$display("test mismatch done");
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		check({cfg_done, cfg_error, crc_error, loc_valid, mem_rd_en}, 5'h00);
		t_config();
		t_clean();
		t_single();
		t_jtag();
		t_overwrite();
		t_mismatch();
		give_verdict();
	end
endmodule
